// ### pin_source.sv
// partner model: external signal source on the timer input pin
module pin_source (
  input wire logic core_clk_i,
  input wire logic level_i,
  output logic timer_in_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // the source is unrelated to the core clock, so edges land mid-cycle
  assign #3 timer_in_o = level_i;
endmodule

// ### sixteen_bit_timer_modes_tb_top.sv
// testbench: register-level scenarios for the 16-bit timer
module sixteen_bit_timer_modes_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import timer16_pkg::*;
  logic clk = 1'b0, rst = 1'b1, hsel = 1'b0, hwrite = 1'b0, pin = 1'b0, wig = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0;
  logic [31:0] hrdata, rd, v1, v2;
  logic hready, hresp, tin, tout, tout_en, irq, o1;
  int miscompares = 0, samples_checked = 0, cyc = 0, irqs = 0, stamp, t0, t1;
  logic [11:0] offs [7] = '{count_high_off, count_low_off, reload_high_off, reload_low_off,
    control_off, prescale_off, 12'h040};
  logic [31:0] rst_val [7] = '{32'h0, 32'h0, 32'hff, 32'hff, 32'h0, 32'h1, 32'h0};
  always #4 clk = ~clk;
  always @(posedge clk) begin
    cyc <= cyc + 1;
    irqs <= irqs + int'(irq === 1'b1);
    if (wig) pin <= ~pin;
  end
  timer16 u_dut (.core_clk_i(clk), .sys_rst_i(rst), .hsel_i(hsel), .haddr_i(haddr),
    .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata),
    .hready_i(hready), .hrdata_o(hrdata), .hreadyout_o(hready), .hresp_o(hresp),
    .timer_in_i(tin), .timer_out_o(tout), .timer_out_en_o(tout_en), .reload_irq_o(irq));
  pin_source u_pin (.core_clk_i(clk), .level_i(pin), .timer_in_o(tin));
  task automatic results();
    $display("miscompares %0d samples_checked %0d", miscompares, samples_checked);
    if (miscompares == 0 && samples_checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wait_for(input bit on_irq);
    for (int n = 0; n < 200; n++) begin
      @(posedge clk);
      if ((on_irq ? irq : hready) === 1'b1) return;
    end
    miscompares++;
    results();
  endtask
  task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {20'h0, a};
    hwrite <= wr;
    htrans <= 2'h2;
    wait_for(1'b0);
    stamp = cyc;
    htrans <= 2'h0;
    hwdata <= d;
    wait_for(1'b0);
    rd = hrdata;
  endtask
  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    bus(1'b1, 12'h040, 32'h5a);
    foreach (offs[i]) begin
      bus(1'b0, offs[i], 32'h0);
      check("reset map", rst_val[i], rd);
    end
    bus(1'b1, count_high_off, 32'h12);
    bus(1'b1, count_low_off, 32'h34);
    bus(1'b0, count_low_off, 32'h0);
    check("live low", 32'h34, rd);
    bus(1'b0, count_high_off, 32'h0);
    check("high byte", 32'h12, rd);
    // start below a byte boundary so a torn read would show
    bus(1'b1, count_high_off, 32'h0);
    bus(1'b1, count_low_off, 32'he0);
    bus(1'b1, control_off, 32'h81);
    bus(1'b0, count_high_off, 32'h0);
    t0 = stamp;
    v1 = rd << 8;
    repeat (40) @(posedge clk);
    bus(1'b0, count_low_off, 32'h0);
    v1 = v1 | rd;
    bus(1'b0, count_high_off, 32'h0);
    t1 = stamp;
    v2 = rd << 8;
    bus(1'b0, count_low_off, 32'h0);
    check("count step", 32'(t1 - t0), (v2 | rd) - v1);
    bus(1'b1, control_off, 32'h01);
    bus(1'b0, count_low_off, 32'h0);
    v1 = rd;
    repeat (10) @(posedge clk);
    bus(1'b0, count_low_off, 32'h0);
    check("stopped", v1, rd);
    bus(1'b1, count_high_off, 32'h0);
    bus(1'b1, count_low_off, 32'h01);
    bus(1'b1, reload_low_off, 32'h05);
    bus(1'b1, reload_high_off, 32'h0);
    bus(1'b1, prescale_off, 32'h03);
    bus(1'b1, control_off, 32'ha1);
    wait_for(1'b1);
    t0 = cyc;
    repeat (2) @(posedge clk);
    o1 = tout;
    wait_for(1'b1);
    check("reload period", 32'd12, 32'(cyc - t0));
    repeat (2) @(posedge clk);
    check("out toggle", {31'h0, ~o1}, {31'h0, tout});
    check("out enable", 32'h1, {31'h0, tout_en});
    bus(1'b1, control_off, 32'h40);
    repeat (3) @(posedge clk);
    check("idle level", 32'h1, {31'h0, tout});
    bus(1'b1, count_low_off, 32'h0);
    bus(1'b1, reload_low_off, 32'h06);
    wig <= 1'b1;
    bus(1'b1, control_off, 32'ha0);
    t0 = stamp;
    bus(1'b1, control_off, 32'he0);
    wait_for(1'b1);
    check("one-shot time", 32'h1, 32'(cyc - t0 inside {[18:22]}));
    t0 = irqs + 1;
    repeat (60) @(posedge clk);
    wig <= 1'b0;
    check("one-shot stops", 32'(t0), 32'(irqs));
    bus(1'b0, control_off, 32'h0);
    check("enable cleared", 32'h0, {31'h0, rd[7]});
    pin <= 1'b0;
    bus(1'b1, count_low_off, 32'h0);
    bus(1'b1, prescale_off, 32'h01);
    bus(1'b1, control_off, 32'h92);
    t0 = irqs;
    repeat (30) @(posedge clk);
    bus(1'b0, count_high_off, 32'h0);
    bus(1'b0, count_low_off, 32'h0);
    check("held count", 32'h0, rd);
    pin <= 1'b1;
    repeat (20) @(posedge clk);
    pin <= 1'b0;
    repeat (5) @(posedge clk);
    pin <= 1'b1;
    repeat (10) @(posedge clk);
    check("no capture irq", 32'(t0), 32'(irqs));
    bus(1'b0, capture_low_off, 32'h0);
    check("capture span", 32'h1, 32'(rd inside {[24:26]}));
    bus(1'b0, status_off, 32'h0);
    check("captured flag", 32'h1, {31'h0, rd[2]});
    results();
  end
endmodule
bind timer16 timer16_checker u_chk (.core_clk_i, .sys_rst_i, .hsel_i, .haddr_i, .htrans_i,
  .hwrite_i, .hwdata_i, .hready_i, .hrdata_o, .hreadyout_o, .hresp_o, .timer_out_o,
  .timer_out_en_o, .reload_irq_o);

// ### timer16.sv
// module: 16-bit reloadable timer with AHB-Lite register slave
// Functional notes
// - one-shot mode counts only prescaled system clock, never input pin edges.
// - one-shot timeout is (reload minus start) times prescale clock periods.
// - continuous mode counts up toward the 16-bit reload value.
// - on reaching reload, interrupt, set count to 0001 and continue.
// - with output function active, output toggles at each reload.
// - continuous mode counts from prescaled system clock, not the pin.
// - capture mode holds count until first qualifying input edge.
// - the starting edge in capture mode raises no interrupt.
// - capture elapsed time is (capture minus start) times prescale periods.
// - reading the count never disturbs counting, reload, toggling or interrupt.
// - enabled high-byte read copies the low byte into a holding register.
// - enabled low-byte read returns the holding register.
// - disabled low-byte read returns the live counter low byte.
// - count byte writes take effect at once, no write holding register.
// - output inverts every time the counter reloads.
// - disabled output follows polarity; enabled output toggles on reload.
// - counting only while the enable bit is one.
//
// Implementation choices: the address map and the AHB-Lite interface to the registers.
module timer16
  import timer16_pkg::*;
#(
  parameter int prescale_width = 16
) (
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic [31:0] hrdata_o,
  output logic hreadyout_o,
  output logic hresp_o,
  input wire logic timer_in_i,
  output logic timer_out_o,
  output logic timer_out_en_o,
  output logic reload_irq_o
);
  import timer16_pkg::*;

  initial begin
    if (prescale_width < 1 || prescale_width > 16) begin
      $error("prescale_width must be 1 to 16");
    end
    // the reset divide factor must be representable in the chosen width
    if (prescale_width < 16 && (prescale_reset >> prescale_width) != 16'h0000) begin
      $error("prescale reset value does not fit prescale_width");
    end
  end

  // counter state
  logic [15:0] count;
  logic [15:0] reload;
  logic [15:0] capture;
  logic [7:0] hold_low;
  logic [prescale_width-1:0] prescale;
  logic [prescale_width-1:0] pre_cnt;
  control_t ctl;
  logic out_level;
  logic started;
  logic captured_flag;

  // pin sampling
  logic in_meta;
  logic in_sync;
  logic in_prev;

  // bus phase state
  logic wr_pend;
  logic rd_pend;
  logic [11:0] ph_addr;

  // per-cycle events
  logic tick;
  logic edge_seen;
  logic at_reload;
  logic reload_evt;
  logic count_wr;
  logic capture_evt;
  logic one_shot_end;
  logic high_read;
  logic [15:0] next_count;

  function automatic logic addr_is(input logic [11:0] a, input logic [11:0] off);
    return a == off;
  endfunction

  // read decode for the data mux; offsets off the map read as zero
  function automatic logic [31:0] read_value(input logic [11:0] a);
    logic [31:0] v;
    v = 32'h0000_0000;
    case (a)
      count_high_off: v = {24'h00_0000, next_count[15:8]};
      count_low_off: v = {24'h00_0000, ctl.enable ? hold_low : next_count[7:0]};
      reload_high_off: v = {24'h00_0000, reload[15:8]};
      reload_low_off: v = {24'h00_0000, reload[7:0]};
      control_off: v = {24'h00_0000, ctl};
      status_off: v = {29'h0000_0000, captured_flag, started, out_level};
      prescale_off: v = 32'(prescale);
      capture_high_off: v = {24'h00_0000, capture[15:8]};
      capture_low_off: v = {24'h00_0000, capture[7:0]};
      default: v = 32'h0000_0000;
    endcase
    return v;
  endfunction

  // address phase capture; slave is always ready, answer is always okay
  wire logic take = hsel_i && hready_i && htrans_i[1];
  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      wr_pend <= 1'b0;
      rd_pend <= 1'b0;
    end else begin
      wr_pend <= take && hwrite_i;
      rd_pend <= take && !hwrite_i;
    end
  end

  // address is kept only on a taken phase so idle cycles leave it alone
  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      ph_addr <= 12'h000;
    end else if (take) begin
      ph_addr <= haddr_i[11:0];
    end
  end

  // input pin synchroniser; first stage read only by the second
  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      in_meta <= 1'b0;
      in_sync <= 1'b0;
    end else begin
      in_meta <= timer_in_i;
      in_sync <= in_meta;
    end
  end

  // edge history; resets to the idle pin level so no false edge follows reset
  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      in_prev <= 1'b0;
    end else begin
      in_prev <= in_sync;
    end
  end

  assign edge_seen = ctl.rise_edge ? (in_sync && !in_prev) : (!in_sync && in_prev);

  // prescaler; cleared whenever the timer is off so each run starts aligned
  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      pre_cnt <= '0;
    end else if (!ctl.enable || (ctl.mode == mode_capture && !started)) begin
      pre_cnt <= '0;
    end else if (tick) begin
      pre_cnt <= '0;
    end else begin
      pre_cnt <= pre_cnt + 1'b1;
    end
  end

  // count only from the system clock; a zero prescale acts as one
  assign tick = ctl.enable && started && (pre_cnt + 1'b1 >= prescale);
  // reload on the tick that would reach the reload value: a period is reload minus start
  assign at_reload = (count + 16'h0001 == reload);
  // capture mode never reloads; its count feeds the capture register and the count byte reads
  assign reload_evt = tick && at_reload && ctl.mode != mode_capture;
  assign one_shot_end = reload_evt && ctl.mode == mode_one_shot;
  assign capture_evt = ctl.enable && ctl.mode == mode_capture && started && edge_seen;
  assign high_read = take && !hwrite_i && addr_is(haddr_i[11:0], count_high_off);
  assign count_wr = wr_pend && (addr_is(ph_addr, count_high_off) || addr_is(ph_addr, count_low_off));

  // capture mode waits for its first edge; free-running modes start at once
  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      started <= 1'b0;
    end else if (!ctl.enable) begin
      // cleared while off so every capture run waits for its own first edge
      started <= 1'b0;
    end else if (ctl.mode != mode_capture || edge_seen) begin
      started <= 1'b1;
    end
  end

  always_comb begin
    next_count = count;
    if (reload_evt) begin
      next_count = count_restart;
    end else if (tick) begin
      next_count = count + 16'h0001;
    end
  end

  // software writes land per byte immediately and override the count
  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      count <= count_reset;
    end else if (count_wr) begin
      if (addr_is(ph_addr, count_high_off)) begin
        count <= {hwdata_i[7:0], count[7:0]};
      end else begin
        count <= {count[15:8], hwdata_i[7:0]};
      end
    end else begin
      count <= next_count;
    end
  end

  // capture on each qualifying edge after the start edge; start edge is silent
  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      capture <= count_reset;
    end else if (capture_evt) begin
      capture <= count;
    end
  end

  // a capture in the same cycle as the clearing status read wins
  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      captured_flag <= 1'b0;
    end else if (capture_evt) begin
      captured_flag <= 1'b1;
    end else if (rd_pend && addr_is(ph_addr, status_off)) begin
      captured_flag <= 1'b0;
    end
  end

  // holding register; reads touch nothing else in the counter path
  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      hold_low <= 8'h00;
    end else if (high_read && ctl.enable) begin
      hold_low <= next_count[7:0];
    end
  end

  // reload bytes land separately; a half-written pair is live at once
  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      reload <= reload_reset;
    end else if (wr_pend && addr_is(ph_addr, reload_high_off)) begin
      reload <= {hwdata_i[7:0], reload[7:0]};
    end else if (wr_pend && addr_is(ph_addr, reload_low_off)) begin
      reload <= {reload[15:8], hwdata_i[7:0]};
    end
  end

  // prescale factor; zero behaves as one
  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      prescale <= prescale_reset[prescale_width-1:0];
    end else if (wr_pend && addr_is(ph_addr, prescale_off)) begin
      prescale <= hwdata_i[prescale_width-1:0];
    end
  end

  // control: one-shot clears its own enable at reload unless software writes
  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      ctl <= control_t'(control_reset);
    end else if (wr_pend && addr_is(ph_addr, control_off)) begin
      ctl <= control_t'(hwdata_i[7:0]);
    end else if (one_shot_end) begin
      ctl.enable <= 1'b0;
    end
  end

  // output level: polarity while off, toggles on reload while on
  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      out_level <= 1'b0;
    end else if (!ctl.enable) begin
      out_level <= ctl.polarity;
    end else if (reload_evt) begin
      out_level <= !out_level;
    end
  end

  // pin level is registered so the pad never sees decode glitches
  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      timer_out_o <= 1'b0;
    end else begin
      timer_out_o <= out_level;
    end
  end

  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      timer_out_en_o <= 1'b0;
    end else begin
      timer_out_en_o <= ctl.out_fn;
    end
  end

  // one-cycle pulse; any latching is left to the interrupt controller
  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      reload_irq_o <= 1'b0;
    end else begin
      reload_irq_o <= reload_evt;
    end
  end

  // read mux registered in the address phase so data stands in the data phase
  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      hrdata_o <= 32'h0000_0000;
    end else if (take && !hwrite_i) begin
      hrdata_o <= read_value(haddr_i[11:0]);
    end
  end

  // zero wait states: every register answers in the cycle after its address phase
  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      hreadyout_o <= 1'b1;
    end else begin
      hreadyout_o <= 1'b1;
    end
  end

  // no error response exists; unmapped accesses read zero and drop writes
  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      hresp_o <= 1'b0;
    end else begin
      hresp_o <= 1'b0;
    end
  end
endmodule

// ### timer16_assertions.sv
// checker: bus answers and pin behaviour of the 16-bit timer
module timer16_checker
  import timer16_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  input wire logic [31:0] hrdata_o,
  input wire logic hreadyout_o,
  input wire logic hresp_o,
  input wire logic timer_out_o,
  input wire logic timer_out_en_o,
  input wire logic reload_irq_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic wr_ctl, rd_bad;
  logic [3:0] age;
  control_t ctl;
  wire logic take = hsel_i & hready_i & htrans_i[1];
  // shadow of the control byte; enable cleared by one-shot is not seen here
  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      wr_ctl <= 1'b0;
      rd_bad <= 1'b0;
      age <= 4'hf;
      ctl <= control_t'(control_reset);
    end else begin
      wr_ctl <= take & hwrite_i & (haddr_i[11:0] == control_off);
      rd_bad <= take & !hwrite_i & (haddr_i[11:0] > capture_low_off);
      if (wr_ctl) begin
        ctl <= control_t'(hwdata_i[7:0]);
        age <= 4'h0;
      end else if (age != 4'hf) begin
        age <= age + 4'h1;
      end
    end
  end
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (sys_rst_i);
  chk_bus_okay: assert property (hreadyout_o && !hresp_o)
    else $error("bus answer not ready or not okay");
  chk_unmapped_zero: assert property (rd_bad |-> hrdata_o == 32'h0)
    else $error("unmapped read not zero");
  chk_irq_enabled: assert property (reload_irq_o |-> ctl.enable || age < 4)
    else $error("irq while disabled");
  chk_irq_no_capture: assert property (reload_irq_o |-> ctl.mode != mode_capture || age < 4)
    else $error("irq in capture mode");
  chk_idle_level: assert property (age > 3 && !ctl.enable |-> timer_out_o == ctl.polarity)
    else $error("idle output not polarity");
  chk_out_fn_follow: assert property (age > 3 |-> timer_out_en_o == ctl.out_fn)
    else $error("output enable wrong");
  chk_out_cause: assert property ($changed(timer_out_o) |->
    (age < 4 || $past(reload_irq_o) || $past(reload_irq_o, 2)) or ##[0:1] reload_irq_o)
    else $error("output changed without reload");
  chk_one_shot_stop: assert property (reload_irq_o && ctl.mode == mode_one_shot && age > 3
    |=> (!reload_irq_o) [*8]) else $error("one-shot kept running");
endmodule

// ### timer16_pkg.sv
// package: register map, field layout and mode codes of the 16-bit timer
package timer16_pkg;
  localparam logic [11:0] count_high_off = 12'h000;
  localparam logic [11:0] count_low_off = 12'h004;
  localparam logic [11:0] reload_high_off = 12'h008;
  localparam logic [11:0] reload_low_off = 12'h00c;
  localparam logic [11:0] control_off = 12'h010;
  localparam logic [11:0] status_off = 12'h014;
  localparam logic [11:0] prescale_off = 12'h018;
  localparam logic [11:0] capture_high_off = 12'h01c;
  localparam logic [11:0] capture_low_off = 12'h020;
  localparam int ctl_enable_bit = 7;
  localparam int ctl_polarity_bit = 6;
  localparam int ctl_out_fn_bit = 5;
  localparam int ctl_edge_bit = 4;
  localparam int ctl_mode_lsb = 0;
  localparam logic [15:0] count_restart = 16'h0001;
  localparam logic [15:0] count_reset = 16'h0000;
  localparam logic [15:0] reload_reset = 16'hffff;
  localparam logic [15:0] prescale_reset = 16'h0001;
  localparam logic [7:0] control_reset = 8'h00;
  typedef enum logic [1:0] {
    mode_one_shot = 2'h0,
    mode_continuous = 2'h1,
    mode_capture = 2'h2
  } timer_mode_t;
  typedef struct packed {
    logic enable;
    logic polarity;
    logic out_fn;
    logic rise_edge;
    logic [1:0] spare;
    timer_mode_t mode;
  } control_t;
  typedef struct packed {
    logic level;
    logic enable;
  } pin_out_t;
endpackage
